// file: src/swdt_defs.svh
// constants for the secure watchdog: offsets, fields, reset values, timing
`ifndef SWDT_DEFS_SVH
`define SWDT_DEFS_SVH
`define SWDT_A_CON0 8'h00
`define SWDT_A_CON1 8'h04
`define SWDT_A_STAT 8'h08
`define SWDT_A_IRQ_STAT 8'h0C
`define SWDT_A_IRQ_MASK 8'h10
`define SWDT_F_LOCK 0
`define SWDT_F_GUARD 1
`define SWDT_F_SEL 0
`define SWDT_F_DIS 1
`define SWDT_ST_PRE 0
`define SWDT_ST_ACC 1
`define SWDT_ST_OVF 2
`define SWDT_CLK_NS 10
`define SWDT_WIN_NS 640
`define SWDT_WIN_CYC (`SWDT_WIN_NS / `SWDT_CLK_NS)
`define SWDT_RST_NS 160
`define SWDT_RST_CYC (`SWDT_RST_NS / `SWDT_CLK_NS)
`define SWDT_DIV_LO 256
`define SWDT_DIV_HI 16384
`define SWDT_TO_RELOAD 16'hFF00
`define SWDT_PW_RELOAD 16'hFFF0
`define SWDT_RELOAD_RST 16'h0000
`define SWDT_PW_RST 14'h0000
`define SWDT_CNT_MAX 16'hFFFF
`endif

// file: src/swdt_pkg.sv
// types for the secure watchdog
`default_nettype none
package swdt_pkg;
  typedef enum logic [2:0] {
    SWDT_NORMAL = 3'b000,
    SWDT_TIMEOUT = 3'b001,
    SWDT_PREWARN = 3'b010,
    SWDT_RESET = 3'b011,
    SWDT_HALT = 3'b100
  } swdt_mode_type;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } swdt_req_type;
  typedef struct packed {
    logic [13:0] pw;
    logic dis;
    logic sel;
  } swdt_cfg_type;
endpackage
`default_nettype wire

// file: src/swdt_top.sv
// secure watchdog timer with init lock, password access and prewarning
//
// Decided for this implementation: the address map and strobed register access.
`include "swdt_defs.svh"
`default_nettype none
module swdt_top import swdt_pkg::*; #(
  parameter int DIV_LO = `SWDT_DIV_LO,
  parameter int DIV_HI = `SWDT_DIV_HI,
  parameter int ACC_WIN = `SWDT_WIN_CYC,
  parameter int RST_LEN = `SWDT_RST_CYC
) (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic SUPV_MODE,
  output logic INIT_LOCK,
  output logic WD_NMI,
  output logic WD_RST_REQ,
  output logic IRQ
);
  swdt_req_type req;
  swdt_mode_type mode_q, mode_d;
  swdt_cfg_type cfg_q, cfg_d;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] reload_q, reload_d;
  logic [13:0] presc_q, presc_d;
  logic [15:0] win_cnt_q, win_cnt_d;
  logic [15:0] rst_cnt_q, rst_cnt_d;
  logic win_q, win_d;
  logic lock_q, lock_d;
  logic dbl_q, dbl_d;
  logic [2:0] st_q, st_d;
  logic [2:0] mask_q, mask_d;
  logic [31:0] rdata_q, rdata_d;
  logic nmi_q, rst_q, irq_q;
  logic tick, counting, ovf, ev_acc, ev_ovf, ev_pre;
  logic wr_con0, pw_ok, first_ok, second_ok;
  logic [13:0] div_m1;

  assign req = '{rd: REG_RD, wr: REG_WR, addr: REG_ADDR, wdata: REG_WDATA};
  assign wr_con0 = req.wr && (req.addr == `SWDT_A_CON0);
  // user password field plus fixed guard bit value
  assign pw_ok = (req.wdata[15:2] == cfg_q.pw);
  assign first_ok = pw_ok && !req.wdata[`SWDT_F_GUARD];
  assign second_ok = pw_ok && req.wdata[`SWDT_F_GUARD];

  //////////////////////////////////////////////////////////////////////////
  // prescaler
  assign div_m1 = cfg_q.sel ? 14'(DIV_HI - 1) : 14'(DIV_LO - 1);
  // at or past the limit, so switching to the short divider never stalls
  assign tick = (presc_q >= div_m1);

  always_comb begin
    presc_d = tick ? 14'h0000 : presc_q + 14'h0001;
  end

  //////////////////////////////////////////////////////////////////////////
  // watchdog sequencer
  // disable only freezes normal mode; timeout and prewarn always count
  assign counting = tick && ((mode_q == SWDT_TIMEOUT) ||
                    (mode_q == SWDT_PREWARN) ||
                    ((mode_q == SWDT_NORMAL) && !cfg_q.dis));
  assign ovf = counting && (cnt_q == `SWDT_CNT_MAX);

  always_comb begin
    mode_d = mode_q;
    cnt_d = counting ? cnt_q + 16'h0001 : cnt_q;
    reload_d = reload_q;
    win_d = win_q;
    win_cnt_d = win_q ? win_cnt_q + 16'h0001 : win_cnt_q;
    rst_cnt_d = rst_cnt_q;
    lock_d = lock_q;
    dbl_d = dbl_q;
    ev_acc = 1'b0;
    ev_ovf = 1'b0;
    ev_pre = 1'b0;
    case (mode_q)
      SWDT_NORMAL, SWDT_TIMEOUT: begin
        if (wr_con0) begin
          if (!win_q) begin
            if (first_ok) begin
              win_d = 1'b1;
              win_cnt_d = 16'h0000;
            end else begin
              ev_acc = 1'b1;
            end
          end else if (second_ok) begin
            // valid service: reload, relock choice, clear double flag
            win_d = 1'b0;
            lock_d = req.wdata[`SWDT_F_LOCK];
            reload_d = req.wdata[31:16];
            dbl_d = 1'b0;
            cnt_d = req.wdata[`SWDT_F_LOCK] ? req.wdata[31:16]
                                            : `SWDT_TO_RELOAD;
            mode_d = req.wdata[`SWDT_F_LOCK] ? SWDT_NORMAL : SWDT_TIMEOUT;
          end else begin
            ev_acc = 1'b1;
          end
        end else if (win_q && (win_cnt_q == 16'(ACC_WIN - 1))) begin
          ev_acc = 1'b1;
        end
        ev_ovf = ovf;
        if (ev_acc || ev_ovf) begin
          mode_d = SWDT_PREWARN;
          cnt_d = `SWDT_PW_RELOAD;
          win_d = 1'b0;
          ev_pre = 1'b1;
        end
      end
      SWDT_PREWARN: begin
        // no access can cancel a pending reset
        if (ovf) begin
          if (dbl_q) begin
            mode_d = SWDT_HALT;
          end else begin
            mode_d = SWDT_RESET;
            dbl_d = 1'b1;
            rst_cnt_d = 16'h0000;
          end
        end
      end
      SWDT_RESET: begin
        rst_cnt_d = rst_cnt_q + 16'h0001;
        if (rst_cnt_q == 16'(RST_LEN - 1)) begin
          mode_d = SWDT_TIMEOUT;
          lock_d = 1'b0;
          cnt_d = `SWDT_TO_RELOAD;
        end
      end
      SWDT_HALT: begin
        // only power-on or hardware reset leaves this
        mode_d = SWDT_HALT;
      end
      default: begin
        mode_d = SWDT_TIMEOUT;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // registers, status and read path
  always_comb begin
    cfg_d = cfg_q;
    mask_d = mask_q;
    rdata_d = 32'h0000_0000;
    st_d = st_q;
    if (req.wr && (req.addr == `SWDT_A_CON1) && SUPV_MODE && !lock_q) begin
      cfg_d.sel = req.wdata[`SWDT_F_SEL];
      cfg_d.dis = req.wdata[`SWDT_F_DIS];
      cfg_d.pw = req.wdata[15:2];
    end
    if (req.wr && (req.addr == `SWDT_A_IRQ_MASK)) begin
      mask_d = req.wdata[2:0];
    end
    if (req.rd) begin
      case (req.addr)
        `SWDT_A_CON0: rdata_d = {reload_q, cfg_q.pw, 1'b0, lock_q};
        `SWDT_A_CON1: rdata_d = {16'h0000, cfg_q.pw, cfg_q.dis, cfg_q.sel};
        `SWDT_A_STAT: rdata_d = {cnt_q, 11'h000, mode_q, win_q, dbl_q};
        `SWDT_A_IRQ_STAT: rdata_d = {29'h0000_0000, st_q};
        `SWDT_A_IRQ_MASK: rdata_d = {29'h0000_0000, mask_q};
        default: rdata_d = 32'h0000_0000;
      endcase
      if (req.addr == `SWDT_A_IRQ_STAT) begin
        st_d = 3'h0;
      end
    end
    // a new event in the clearing read's cycle is kept
    st_d[`SWDT_ST_PRE] = st_d[`SWDT_ST_PRE] | ev_pre;
    st_d[`SWDT_ST_ACC] = st_d[`SWDT_ST_ACC] | ev_acc;
    st_d[`SWDT_ST_OVF] = st_d[`SWDT_ST_OVF] | ev_ovf;
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      // starts unlocked in timeout mode so boot code can configure
      mode_q <= SWDT_TIMEOUT;
      cfg_q <= '{pw: `SWDT_PW_RST, dis: 1'b0, sel: 1'b0};
      cnt_q <= `SWDT_TO_RELOAD;
      reload_q <= `SWDT_RELOAD_RST;
      presc_q <= 14'h0000;
      win_cnt_q <= 16'h0000;
      rst_cnt_q <= 16'h0000;
      win_q <= 1'b0;
      lock_q <= 1'b0;
      dbl_q <= 1'b0;
      st_q <= 3'h0;
      mask_q <= 3'h0;
      rdata_q <= 32'h0000_0000;
      nmi_q <= 1'b0;
      rst_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      cfg_q <= cfg_d;
      cnt_q <= cnt_d;
      reload_q <= reload_d;
      presc_q <= presc_d;
      win_cnt_q <= win_cnt_d;
      rst_cnt_q <= rst_cnt_d;
      win_q <= win_d;
      lock_q <= lock_d;
      dbl_q <= dbl_d;
      st_q <= st_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      nmi_q <= (mode_d == SWDT_PREWARN);
      rst_q <= (mode_d == SWDT_RESET) || (mode_d == SWDT_HALT);
      irq_q <= |(st_d & mask_d);
    end
  end

  assign REG_RDATA = rdata_q;
  assign INIT_LOCK = lock_q;
  assign WD_NMI = nmi_q;
  assign WD_RST_REQ = rst_q;
  assign IRQ = irq_q;

  //////////////////////////////////////////////////////////////////////////
  // assertions
  property p_halt_holds;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (mode_q == SWDT_HALT) |=> WD_RST_REQ && (mode_q == SWDT_HALT);
  endproperty
  a_halt_holds: assert property (p_halt_holds)
    else $error("halt state left or reset dropped");

  property p_nmi_first;
    @(posedge REF_CLK) disable iff (SYS_RST)
    $rose(WD_RST_REQ) |-> $past(WD_NMI);
  endproperty
  a_nmi_first: assert property (p_nmi_first)
    else $error("reset raised without prewarning");

  property p_bad_first;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (wr_con0 && !win_q && !first_ok && (mode_q == SWDT_NORMAL ||
     mode_q == SWDT_TIMEOUT)) |=> WD_NMI && (cnt_q == `SWDT_PW_RELOAD);
  endproperty
  a_bad_first: assert property (p_bad_first)
    else $error("bad password did not start prewarning");

  property p_late_second;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (win_q && !wr_con0 && (win_cnt_q == 16'(ACC_WIN - 1)) &&
     (mode_q == SWDT_NORMAL || mode_q == SWDT_TIMEOUT)) |=> WD_NMI;
  endproperty
  a_late_second: assert property (p_late_second)
    else $error("expired access window not flagged");

  property p_overflow;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (ovf && (mode_q == SWDT_NORMAL)) |=> (mode_q == SWDT_PREWARN) ##0
      st_q[`SWDT_ST_OVF];
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("overflow did not start prewarning");

  property p_protect;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (req.wr && (req.addr == `SWDT_A_CON1) && (lock_q || !SUPV_MODE))
      |=> $stable(cfg_q);
  endproperty
  a_protect: assert property (p_protect)
    else $error("protected config changed");

  property p_service;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (wr_con0 && win_q && second_ok && req.wdata[`SWDT_F_LOCK] && !ovf &&
     (mode_q == SWDT_NORMAL || mode_q == SWDT_TIMEOUT))
      |=> (cnt_q == $past(req.wdata[31:16])) && INIT_LOCK && !dbl_q;
  endproperty
  a_service: assert property (p_service)
    else $error("service did not reload user value");

  property p_presc;
    @(posedge REF_CLK) disable iff (SYS_RST)
    !tick |=> (presc_q == $past(presc_q) + 14'h0001);
  endproperty
  a_presc: assert property (p_presc)
    else $error("prescaler tick at wrong count");

  property p_disabled;
    @(posedge REF_CLK) disable iff (SYS_RST)
    ((mode_q == SWDT_NORMAL) && cfg_q.dis && !wr_con0 && !win_q)
      |=> $stable(cnt_q);
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("disabled counter moved");
endmodule // swdt_top
`default_nettype wire

// file: tb/swdt_rst_ctl.sv
// reset controller model: measures watchdog reset requests
`default_nettype none
module swdt_rst_ctl (
  input wire logic clk,
  input wire logic por,
  input wire logic req,
  output logic [7:0] len
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] run;
  // len keeps the last finished request, so a held one never lands
  always_ff @(posedge clk) begin
    if (por) begin
      run <= 8'h00;
      len <= 8'h00;
    end else if (req) begin
      run <= run + 8'h01;
    end else if (run != 8'h00) begin
      len <= run;
      run <= 8'h00;
    end
  end
endmodule // swdt_rst_ctl
`default_nettype wire

// file: tb/swdt_top_tb.sv
// self-checking bench for the secure watchdog
`include "swdt_defs.svh"
`default_nettype none
module swdt_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RLEN = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic supv = 1'b0;
  logic [31:0] rdata;
  logic lock, nmi, rreq, irq, rd_seen;
  logic [7:0] rlen;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] seed = 32'he788;
  logic [13:0] pw;
  int miscompares = 0;
  int n_tests = 0;
  int n;
  swdt_top #(.DIV_LO(4), .DIV_HI(8), .ACC_WIN(8), .RST_LEN(RLEN)) dut_u (
    .REF_CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .SUPV_MODE(supv),
    .INIT_LOCK(lock), .WD_NMI(nmi), .WD_RST_REQ(rreq), .IRQ(irq));
  swdt_rst_ctl rc_u (.clk(clk), .por(rst), .req(rreq), .len(rlen));
  initial begin
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // one gap cycle after each strobe keeps drivers single per step
  task automatic bus(input logic [7:0] a, input logic [31:0] d,
      input logic w, input logic r);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= r;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(a, 32'h0000_0000, 1'b0, 1'b1);
  endtask
  task automatic acc(input logic [13:0] p, input logic [15:0] rl,
      input logic lk, input logic g2, input int gap);
    bus(`SWDT_A_CON0, {16'h0000, p, 2'b00}, 1'b1, 1'b0);
    repeat (gap) @(posedge clk);
    bus(`SWDT_A_CON0, {rl, p, g2, lk}, 1'b1, 1'b0);
  endtask
  // k 0 waits on the prewarning, k 1 on the reset request
  task automatic wait_on(input int k, input int lim);
    n = 0;
    while ((k == 0 ? nmi : rreq) !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  always @(posedge clk) begin
    if (rd_seen === 1'b1) begin
      check(rdata & msk_q.pop_front(), exp_q.pop_front());
    end
    rd_seen <= rd;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    miscompares++;
    final_report;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdx(`SWDT_A_STAT, 32'h0000_0004, 32'h0000_ffff);
    rdx(8'h40, 32'h0000_0000, 32'hffff_ffff);
    bus(`SWDT_A_IRQ_MASK, 32'h0000_0007, 1'b1, 1'b0);
    rdx(`SWDT_A_IRQ_MASK, 32'h0000_0007, 32'hffff_ffff);
    bus(`SWDT_A_CON1, 32'h0000_0554, 1'b1, 1'b0);
    rdx(`SWDT_A_CON1, 32'h0000_0000, 32'hffff_ffff);
    acc(14'h0000, 16'hfff0, 1'b1, 1'b1, 0);
    cyc(1);
    check(lock, 1'b1);
    rdx(`SWDT_A_CON0, 32'hfff0_0001, 32'hffff_ffff);
    rdx(`SWDT_A_STAT, 32'h0000_0000, 32'h0000_ffff);
    wait_on(0, 200);
    check(n >= 46 && n <= 72, 1'b1);
    check(irq, 1'b1);
    rdx(`SWDT_A_IRQ_STAT, 32'h0000_0005, 32'h0000_0007);
    cyc(2);
    check(irq, 1'b0);
    check(rreq, 1'b0);
    wait_on(1, 200);
    cyc(RLEN + 4);
    check(rlen, RLEN);
    check(lock, 1'b0);
    rdx(`SWDT_A_STAT, 32'h0000_0005, 32'h0000_ffff);
    // late second write after a watchdog reset: must stay in reset
    acc(14'h0000, 16'hfff0, 1'b1, 1'b1, 10);
    cyc(1);
    check(nmi, 1'b1);
    rdx(`SWDT_A_IRQ_STAT, 32'h0000_0002, 32'h0000_0002);
    wait_on(1, 200);
    cyc(RLEN + 20);
    check(rreq, 1'b1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    check(rreq, 1'b0);
    acc(14'h0000, 16'hfff0, 1'b1, 1'b0, 0);
    cyc(1);
    check(nmi, 1'b1);
    wait_on(1, 200);
    cyc(RLEN + 4);
    check(rreq, 1'b0);
    seed = lfsr(seed);
    pw = seed[13:0] | 14'h0001;
    @(posedge clk);
    supv <= 1'b1;
    bus(`SWDT_A_CON1, {16'h0000, pw, 2'b10}, 1'b1, 1'b0);
    acc(pw, 16'hfff0, 1'b1, 1'b1, 0);
    cyc(150);
    check(nmi, 1'b0);
    bus(`SWDT_A_CON1, {16'h0000, pw, 2'b01}, 1'b1, 1'b0);
    acc(pw, 16'hfff0, 1'b1, 1'b1, 0);
    cyc(150);
    check(nmi, 1'b0);
    acc(pw, 16'hfff0, 1'b0, 1'b1, 0);
    bus(`SWDT_A_CON1, {16'h0000, pw, 2'b01}, 1'b1, 1'b0);
    acc(pw, 16'hfff0, 1'b1, 1'b1, 0);
    wait_on(0, 300);
    check(n >= 108 && n <= 140, 1'b1);
    wait_on(1, 200);
    cyc(RLEN + 4);
    bus(`SWDT_A_CON1, {16'h0000, pw, 2'b10}, 1'b1, 1'b0);
    acc(14'h0000, 16'hfff0, 1'b1, 1'b1, 0);
    cyc(1);
    check(nmi, 1'b1);
    final_report;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
endmodule // swdt_top_tb
`default_nettype wire
